//--- logic/actc_top.sv
`timescale 1ns/1ps
module actc_top
#(
	parameter int unsigned TRIG_COUNT = actc_pkg::ACTC_TRIG_COUNT
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [actc_pkg::ACTC_ADDR_W-1:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [actc_pkg::ACTC_DATA_W-1:0] avs_writedata,
	input wire logic [actc_pkg::ACTC_BE_W-1:0] avs_byteenable,
	output logic [actc_pkg::ACTC_DATA_W-1:0] avs_readdata,
	output logic avs_waitrequest,
	input wire logic [TRIG_COUNT-1:0] ord_triggers,
	input wire logic [TRIG_COUNT-1:0] pre_triggers,
	output logic ord_start,
	output logic pre_start,
	input wire logic ord_started,
	input wire logic pre_started,
	input wire logic ord_channel_done,
	input wire logic ord_last_channel,
	input wire logic pre_channel_done,
	input wire logic pre_last_channel,
	input wire logic ord_result_read,
	output logic result_left_align,
	output logic overflow_detect_enable,
	output logic irq
);
	import actc_pkg::*;

	// Refuse trigger counts the selector field cannot address
	if (TRIG_COUNT < 1 || TRIG_COUNT > (1 << ACTC_SRC_W))
	begin : g_bad_count
		$error("actc_top: TRIG_COUNT out of range");
	end

	typedef struct packed {
		logic [ACTC_SRC_W-1:0] ord_src;
		logic [1:0] ord_edge;
		logic ord_soft;
		logic [ACTC_SRC_W-1:0] pre_src;
		logic [1:0] pre_edge;
		logic pre_soft;
		logic align;
		logic per_ch;
		logic seq_mode;
		logic [ACTC_ST_W-1:0] status;
		logic [ACTC_ST_W-1:0] mask;
		logic result_pending;
		logic ack;
		logic [ACTC_DATA_W-1:0] rdata;
		logic ord_start;
		logic pre_start;
	} actc_state_t;

	actc_state_t st_ff;
	actc_state_t nxt_st;

	logic ord_hw_pulse;
	logic pre_hw_pulse;
	logic bus_req;
	logic taken;
	logic wr_ctrl2;
	logic wr_mode;
	logic wr_mask;
	logic rd_status;
	logic [ACTC_DATA_W-1:0] ctrl2_word;
	logic [ACTC_DATA_W-1:0] ctrl2_new;
	logic [ACTC_DATA_W-1:0] mode_new;
	logic [ACTC_DATA_W-1:0] mask_new;
	logic [ACTC_DATA_W-1:0] rd_word;
	logic ord_soft_set;
	logic pre_soft_set;
	logic group_end_evt;
	logic ord_end_evt;
	logic pre_end_evt;
	logic ovf_evt;
	logic [ACTC_ST_W-1:0] st_set;
	logic [ACTC_ST_W-1:0] st_clr;

	// Byte-lane merge for partial writes
	function automatic logic [ACTC_DATA_W-1:0] lane_merge(
		input logic [ACTC_DATA_W-1:0] old_w,
		input logic [ACTC_DATA_W-1:0] new_w,
		input logic [ACTC_BE_W-1:0] be
	);
		logic [ACTC_DATA_W-1:0] res;
		res = old_w;
		for (int i = 0; i < ACTC_BE_W; i++)
		begin
			if (be[i])
				res[8*i +: 8] = new_w[8*i +: 8];
		end
		return res;
	endfunction

	// Trigger qualification, one instance per group
	actc_edge_qual #(
		.TRIG_COUNT(TRIG_COUNT)
	) u_ord_qual (
		.clk(clk),
		.reset(reset),
		.trig_in(ord_triggers),
		.source_sel(st_ff.ord_src),
		.edge_sel(st_ff.ord_edge),
		.start_pulse(ord_hw_pulse)
	);

	actc_edge_qual #(
		.TRIG_COUNT(TRIG_COUNT)
	) u_pre_qual (
		.clk(clk),
		.reset(reset),
		.trig_in(pre_triggers),
		.source_sel(st_ff.pre_src),
		.edge_sel(st_ff.pre_edge),
		.start_pulse(pre_hw_pulse)
	);

	// Control word image; bits not assembled here read as zero
	always_comb
	begin
		ctrl2_word = ACTC_WORD_RST;
		ctrl2_word[ACTC_OSRC_POS +: ACTC_SRC_W] = st_ff.ord_src;
		ctrl2_word[ACTC_OEDGE_POS +: 2] = st_ff.ord_edge;
		ctrl2_word[ACTC_OSOFT_POS] = st_ff.ord_soft;
		ctrl2_word[ACTC_PSRC_POS +: ACTC_SRC_W] = st_ff.pre_src;
		ctrl2_word[ACTC_PEDGE_POS +: 2] = st_ff.pre_edge;
		ctrl2_word[ACTC_PSOFT_POS] = st_ff.pre_soft;
		ctrl2_word[ACTC_ALIGN_POS] = st_ff.align;
		ctrl2_word[ACTC_PERCH_POS] = st_ff.per_ch;
	end

	// Read multiplexer; unmapped offsets answer zero
	always_comb
	begin
		rd_word = ACTC_WORD_RST;
		unique case (avs_address)
			ACTC_STATUS_OFS: rd_word[ACTC_ST_W-1:0] = st_ff.status;
			ACTC_MODE_OFS: rd_word[ACTC_SEQ_POS] = st_ff.seq_mode;
			ACTC_CTRL2_OFS: rd_word = ctrl2_word;
			ACTC_MASK_OFS: rd_word[ACTC_ST_W-1:0] = st_ff.mask;
			default: rd_word = ACTC_WORD_RST;
		endcase
	end

	// Bus decode: one wait state, request taken while ack is up
	assign bus_req = avs_read | avs_write;
	assign taken = bus_req & st_ff.ack;
	assign wr_ctrl2 = taken & avs_write & (avs_address == ACTC_CTRL2_OFS);
	assign wr_mode = taken & avs_write & (avs_address == ACTC_MODE_OFS);
	assign wr_mask = taken & avs_write & (avs_address == ACTC_MASK_OFS);
	assign rd_status = taken & avs_read & (avs_address == ACTC_STATUS_OFS);
	assign ctrl2_new = lane_merge(ctrl2_word, avs_writedata, avs_byteenable);
	assign mode_new = lane_merge(ACTC_WORD_RST, avs_writedata, avs_byteenable);
	assign mask_new = lane_merge(ACTC_WORD_RST, avs_writedata, avs_byteenable);
	assign ord_soft_set = wr_ctrl2 & ctrl2_new[ACTC_OSOFT_POS];
	assign pre_soft_set = wr_ctrl2 & ctrl2_new[ACTC_PSOFT_POS];

	// Converter events; in sequence mode only the last channel ends a group
	assign group_end_evt = ord_channel_done & (~st_ff.seq_mode | ord_last_channel);
	assign ord_end_evt = ord_channel_done & (st_ff.per_ch | ~st_ff.seq_mode | ord_last_channel);
	assign pre_end_evt = pre_channel_done & (~st_ff.seq_mode | pre_last_channel);
	// A result read in the same cycle frees the slot, so no overflow then
	assign ovf_evt = st_ff.per_ch & ord_channel_done & st_ff.result_pending & ~ord_result_read;

	always_comb
	begin
		st_set = '0;
		st_set[ACTC_ST_GROUP] = group_end_evt;
		st_set[ACTC_ST_ORD] = ord_end_evt;
		st_set[ACTC_ST_PRE] = pre_end_evt;
		st_set[ACTC_ST_OVF] = ovf_evt;
	end

	// Only bits the master actually saw are cleared by its read
	assign st_clr = rd_status ? st_ff.rdata[ACTC_ST_W-1:0] : '0;

	// Next-state logic of the whole block
	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.ack = bus_req & ~st_ff.ack;
		if (bus_req & ~st_ff.ack)
			nxt_st.rdata = avs_read ? rd_word : ACTC_WORD_RST;
		if (wr_ctrl2)
		begin
			nxt_st.ord_src = ctrl2_new[ACTC_OSRC_POS +: ACTC_SRC_W];
			nxt_st.ord_edge = ctrl2_new[ACTC_OEDGE_POS +: 2];
			nxt_st.pre_src = ctrl2_new[ACTC_PSRC_POS +: ACTC_SRC_W];
			nxt_st.pre_edge = ctrl2_new[ACTC_PEDGE_POS +: 2];
			nxt_st.align = ctrl2_new[ACTC_ALIGN_POS];
			nxt_st.per_ch = ctrl2_new[ACTC_PERCH_POS];
			nxt_st.ord_soft = ctrl2_new[ACTC_OSOFT_POS];
			nxt_st.pre_soft = ctrl2_new[ACTC_PSOFT_POS];
		end
		// Converter start acknowledge clears the soft bit unless set again now
		if (ord_started & ~ord_soft_set)
			nxt_st.ord_soft = 1'b0;
		if (pre_started & ~pre_soft_set)
			nxt_st.pre_soft = 1'b0;
		if (wr_mode)
			nxt_st.seq_mode = mode_new[ACTC_SEQ_POS];
		if (wr_mask)
			nxt_st.mask = mask_new[ACTC_ST_W-1:0];
		// Set wins over a read-clear in the same cycle
		nxt_st.status = (st_ff.status & ~st_clr) | st_set;
		// A new result outranks a read of the old one
		if (ord_channel_done)
			nxt_st.result_pending = 1'b1;
		else if (ord_result_read)
			nxt_st.result_pending = 1'b0;
		nxt_st.ord_start = ord_hw_pulse | ord_soft_set;
		nxt_st.pre_start = pre_hw_pulse | pre_soft_set;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			st_ff <= '0;
			st_ff.ord_src <= ACTC_SRC_RST;
			st_ff.pre_src <= ACTC_SRC_RST;
			st_ff.ord_edge <= ACTC_EDGE_RST;
			st_ff.pre_edge <= ACTC_EDGE_RST;
			st_ff.status <= ACTC_STATUS_RST;
			st_ff.mask <= ACTC_MASK_RST;
			st_ff.rdata <= ACTC_WORD_RST;
		end
		else
			st_ff <= nxt_st;
	end

	// Outputs
	assign avs_waitrequest = bus_req & ~st_ff.ack;
	assign avs_readdata = st_ff.rdata;
	assign ord_start = st_ff.ord_start;
	assign pre_start = st_ff.pre_start;
	assign result_left_align = st_ff.align;
	assign overflow_detect_enable = st_ff.per_ch;
	assign irq = |(st_ff.status & st_ff.mask);

	a_soft_ord_start: assert property (@(posedge clk) disable iff (reset)
		ord_soft_set |=> ord_start && st_ff.ord_soft)
		else $error("ordinary soft start gave no start pulse");

	a_soft_ord_clear: assert property (@(posedge clk) disable iff (reset)
		(ord_started && !ord_soft_set) |=> !st_ff.ord_soft)
		else $error("ordinary soft start bit not cleared on start");

	a_soft_pre_clear: assert property (@(posedge clk) disable iff (reset)
		(pre_started && !pre_soft_set) |=> !st_ff.pre_soft)
		else $error("preempted soft start bit not cleared on start");

	a_hw_start_pass: assert property (@(posedge clk) disable iff (reset)
		(ord_hw_pulse || pre_hw_pulse) |=> (ord_start || pre_start))
		else $error("hardware trigger gave no start pulse");

	a_group_end_last: assert property (@(posedge clk) disable iff (reset)
		$rose(st_ff.status[ACTC_ST_GROUP]) |-> $past(ord_channel_done && (!st_ff.seq_mode || ord_last_channel)))
		else $error("group end flag raised before the last channel");

	a_per_chan_flag: assert property (@(posedge clk) disable iff (reset)
		(ord_channel_done && st_ff.per_ch) |=> st_ff.status[ACTC_ST_ORD])
		else $error("per channel end flag not raised");

	a_ovf_detect: assert property (@(posedge clk) disable iff (reset)
		(st_ff.per_ch && ord_channel_done && st_ff.result_pending && !ord_result_read)
		|=> st_ff.status[ACTC_ST_OVF])
		else $error("overflow not detected with per channel flag on");

	a_ovf_irq_gate: assert property (@(posedge clk) disable iff (reset)
		(st_ff.status == (4'h1 << ACTC_ST_OVF)) |-> (irq == st_ff.mask[ACTC_ST_OVF]))
		else $error("overflow interrupt not gated by its enable");

	a_src_reset_zero: assert property (@(posedge clk)
		$past(reset) |-> (st_ff.ord_src == ACTC_SRC_RST && st_ff.pre_src == ACTC_SRC_RST))
		else $error("trigger source fields not zero after reset");

	a_bus_one_wait: assert property (@(posedge clk) disable iff (reset)
		(avs_read && avs_waitrequest) |=> !avs_waitrequest)
		else $error("read not answered after one wait state");

	a_soft_pre_start: assert property (@(posedge clk) disable iff (reset)
		pre_soft_set |=> pre_start && st_ff.pre_soft)
		else $error("preempted soft start gave no start pulse");

	a_pre_end_last: assert property (@(posedge clk) disable iff (reset)
		$rose(st_ff.status[ACTC_ST_PRE]) |-> $past(pre_channel_done && (!st_ff.seq_mode || pre_last_channel)))
		else $error("preempted end flag raised before the last channel");

endmodule

//--- logic/actc_pkg.sv
package actc_pkg;

	// Slave port geometry
	localparam int unsigned ACTC_ADDR_W = 4;
	localparam int unsigned ACTC_DATA_W = 32;
	localparam int unsigned ACTC_BE_W = 4;

	// Register byte offsets
	localparam logic [3:0] ACTC_STATUS_OFS = 4'h0;
	localparam logic [3:0] ACTC_MODE_OFS = 4'h4;
	localparam logic [3:0] ACTC_CTRL2_OFS = 4'h8;
	localparam logic [3:0] ACTC_MASK_OFS = 4'hc;

	// Trigger selection geometry
	localparam int unsigned ACTC_SRC_W = 4;
	localparam int unsigned ACTC_TRIG_COUNT = 16;

	// Field positions in the trigger and format control word
	localparam int unsigned ACTC_OSRC_POS = 0;
	localparam int unsigned ACTC_OEDGE_POS = 4;
	localparam int unsigned ACTC_OSOFT_POS = 6;
	localparam int unsigned ACTC_PSRC_POS = 8;
	localparam int unsigned ACTC_PEDGE_POS = 12;
	localparam int unsigned ACTC_PSOFT_POS = 14;
	localparam int unsigned ACTC_ALIGN_POS = 16;
	localparam int unsigned ACTC_PERCH_POS = 17;

	// Field positions in the mode word
	localparam int unsigned ACTC_SEQ_POS = 0;

	// Status and mask bit positions
	localparam int unsigned ACTC_ST_W = 4;
	localparam int unsigned ACTC_ST_GROUP = 0;
	localparam int unsigned ACTC_ST_ORD = 1;
	localparam int unsigned ACTC_ST_PRE = 2;
	localparam int unsigned ACTC_ST_OVF = 3;

	// Edge qualification codes
	localparam logic [1:0] ACTC_EDGE_NONE = 2'h0;
	localparam logic [1:0] ACTC_EDGE_RISE = 2'h1;
	localparam logic [1:0] ACTC_EDGE_FALL = 2'h2;
	localparam logic [1:0] ACTC_EDGE_ANY = 2'h3;

	// Values after reset
	localparam logic [3:0] ACTC_SRC_RST = 4'h0;
	localparam logic [1:0] ACTC_EDGE_RST = 2'h0;
	localparam logic [3:0] ACTC_STATUS_RST = 4'h0;
	localparam logic [3:0] ACTC_MASK_RST = 4'h0;
	localparam logic [31:0] ACTC_WORD_RST = 32'h0000_0000;

endpackage

//--- logic/actc_edge_qual.sv
`timescale 1ns/1ps
module actc_edge_qual
#(
	parameter int unsigned TRIG_COUNT = actc_pkg::ACTC_TRIG_COUNT
)
(
	input wire logic clk,
	input wire logic reset,
	input wire logic [TRIG_COUNT-1:0] trig_in,
	input wire logic [actc_pkg::ACTC_SRC_W-1:0] source_sel,
	input wire logic [1:0] edge_sel,
	output logic start_pulse
);
	import actc_pkg::*;

	// Refuse trigger counts the selector field cannot address
	if (TRIG_COUNT < 1 || TRIG_COUNT > (1 << ACTC_SRC_W))
	begin : g_bad_count
		$error("actc_edge_qual: TRIG_COUNT out of range");
	end

	typedef struct packed {
		logic [TRIG_COUNT-1:0] sync1;
		logic [TRIG_COUNT-1:0] sync2;
		logic [TRIG_COUNT-1:0] prev;
		logic pulse;
	} actc_eq_state_t;

	actc_eq_state_t st_ff;
	actc_eq_state_t nxt_st;
	logic cur_level;
	logic old_level;
	logic hit;

	// Whole vector is synchronised so a source change never fakes an edge
	always_comb
	begin
		cur_level = 1'b0;
		old_level = 1'b0;
		if (32'(source_sel) < TRIG_COUNT)
		begin
			cur_level = st_ff.sync2[source_sel];
			old_level = st_ff.prev[source_sel];
		end
		unique case (edge_sel)
			ACTC_EDGE_NONE: hit = 1'b0;
			ACTC_EDGE_RISE: hit = cur_level & ~old_level;
			ACTC_EDGE_FALL: hit = ~cur_level & old_level;
			ACTC_EDGE_ANY: hit = cur_level ^ old_level;
		endcase
		nxt_st = st_ff;
		nxt_st.sync1 = trig_in;
		nxt_st.sync2 = st_ff.sync1;
		nxt_st.prev = st_ff.sync2;
		nxt_st.pulse = hit;
	end

	// State register
	always_ff @(posedge clk)
	begin
		if (reset)
			st_ff <= '0;
		else
			st_ff <= nxt_st;
	end

	assign start_pulse = st_ff.pulse;

	a_edge_off_quiet: assert property (@(posedge clk) disable iff (reset)
		$past(edge_sel) == ACTC_EDGE_NONE |-> !start_pulse)
		else $error("start pulse with edge triggering off");

	a_rise_one_pulse: assert property (@(posedge clk) disable iff (reset)
		(edge_sel == ACTC_EDGE_RISE && cur_level && !old_level) |=> start_pulse ##1 !start_pulse)
		else $error("rising edge did not give exactly one pulse");

	a_fall_only: assert property (@(posedge clk) disable iff (reset)
		(edge_sel == ACTC_EDGE_FALL && cur_level) |=> !start_pulse)
		else $error("falling mode fired on a high level");

endmodule

//--- sim/actc_conv_model.sv
`timescale 1ns/1ps
module actc_conv_model
(
	input wire logic clk,
	input wire logic reset,
	input wire logic ord_start,
	input wire logic pre_start,
	input wire logic [3:0] lat,
	input wire logic [3:0] n_chan,
	output logic ord_started,
	output logic pre_started,
	output logic ord_channel_done,
	output logic ord_last_channel,
	output logic pre_channel_done,
	output logic pre_last_channel
);
	initial
	begin
		{ord_started, pre_started, ord_channel_done, pre_channel_done} = 4'h0;
		{ord_last_channel, pre_last_channel} = 2'h0;
	end

	// Ordinary converter; busy for a whole sequence, so a start meanwhile is lost
	always @(posedge clk)
		if (!reset && ord_start === 1'b1)
		begin
			repeat (lat) @(posedge clk);
			ord_started <= 1'b1;
			@(posedge clk);
			ord_started <= 1'b0;
			for (int i = 0; i < n_chan; i++)
			begin
				repeat (2) @(posedge clk);
				ord_channel_done <= 1'b1;
				ord_last_channel <= (i == n_chan - 1);
				@(posedge clk);
				ord_channel_done <= 1'b0;
				ord_last_channel <= ~ord_last_channel; // Qualifier is not held after the pulse
			end
		end

	// Preempted converter, same timing
	always @(posedge clk)
		if (!reset && pre_start === 1'b1)
		begin
			repeat (lat) @(posedge clk);
			pre_started <= 1'b1;
			@(posedge clk);
			pre_started <= 1'b0;
			for (int i = 0; i < n_chan; i++)
			begin
				repeat (2) @(posedge clk);
				pre_channel_done <= 1'b1;
				pre_last_channel <= (i == n_chan - 1);
				@(posedge clk);
				pre_channel_done <= 1'b0;
				pre_last_channel <= ~pre_last_channel;
			end
		end
endmodule

//--- sim/actc_top_tb.sv
`timescale 1ns/1ps
module actc_top_tb;
	import actc_pkg::*;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [3:0] avs_address = 4'h0;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h0;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic [15:0] ord_trig = 16'h0;
	logic [15:0] pre_trig = 16'h0;
	logic ord_start, pre_start, ord_started, pre_started, ord_done, ord_last, pre_done, pre_last;
	logic result_read = 1'b0;
	logic left_align, ovf_en, irq;
	logic [3:0] lat = 4'h6;
	logic [3:0] n_chan = 4'h1;
	logic [31:0] rd;
	int n_fail = 0;
	int checks_done = 0;
	int n_ord = 0;
	int n_pre = 0;

	always #50 clk = ~clk;

	// Count start pulses in the cycle they stand
	always @(posedge clk)
	begin
		if (ord_start === 1'b1) n_ord++;
		if (pre_start === 1'b1) n_pre++;
	end

	actc_top dut_u (.clk(clk), .reset(reset), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
		.avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .ord_triggers(ord_trig),
		.pre_triggers(pre_trig), .ord_start(ord_start), .pre_start(pre_start),
		.ord_started(ord_started), .pre_started(pre_started), .ord_channel_done(ord_done),
		.ord_last_channel(ord_last), .pre_channel_done(pre_done), .pre_last_channel(pre_last),
		.ord_result_read(result_read), .result_left_align(left_align),
		.overflow_detect_enable(ovf_en), .irq(irq));

	actc_conv_model conv_u (.clk(clk), .reset(reset), .ord_start(ord_start), .pre_start(pre_start),
		.lat(lat), .n_chan(n_chan), .ord_started(ord_started), .pre_started(pre_started),
		.ord_channel_done(ord_done), .ord_last_channel(ord_last), .pre_channel_done(pre_done),
		.pre_last_channel(pre_last));

	task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	// One Avalon access; held until waitrequest is seen low, then one idle edge
	task bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
		avs_address <= a;
		avs_writedata <= d;
		avs_read <= !wr;
		avs_write <= wr;
		// No local limit: a hung slave is caught by the watchdog
		do
			@(posedge clk);
		while (avs_waitrequest !== 1'b0);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask

	// Every even offset, mapped or not, reads zero after reset
	task t_reset;
		check("irq at reset", irq, 32'h0);
		for (int a = 0; a < 16; a += 2)
		begin
			bus(1'b0, a[3:0], 32'h0);
			check("reset word", rd, 32'h0);
		end
		$display("test reset done");
	endtask

	// Slow converter, so the bit must stand until the start is reported
	task t_soft;
		n_ord = 0;
		n_pre = 0;
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0000_0040);
		bus(1'b0, ACTC_CTRL2_OFS, 32'h0);
		check("ord soft bit", rd, 32'h0000_0040);
		repeat (16) @(posedge clk);
		bus(1'b0, ACTC_CTRL2_OFS, 32'h0);
		check("ord soft cleared", rd, 32'h0);
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0000_4000);
		bus(1'b0, ACTC_CTRL2_OFS, 32'h0);
		check("pre soft bit", rd, 32'h0000_4000);
		repeat (16) @(posedge clk);
		bus(1'b0, ACTC_CTRL2_OFS, 32'h0);
		check("pre soft cleared", rd, 32'h0);
		check("start counts", {n_ord[15:0], n_pre[15:0]}, 32'h0001_0001);
		bus(1'b0, ACTC_STATUS_OFS, 32'h0);
		check("status after runs", rd, 32'h7);
		$display("test soft start done");
	endtask

	// Each edge code on both groups; unselected lines toggle too
	task t_edge;
		lat <= 4'h1;
		for (int c = 0; c < 4; c++)
		begin
			n_ord = 0;
			n_pre = 0;
			bus(1'b1, ACTC_CTRL2_OFS, {18'h0, c[1:0], 4'h5, 2'h0, c[1:0], 4'h3});
			for (int s = 0; s < 4; s++)
			begin
				ord_trig <= ord_trig ^ (s[0] ? 16'h0020 : 16'h0008);
				pre_trig <= pre_trig ^ (s[0] ? 16'h0008 : 16'h0020);
				repeat (8) @(posedge clk);
			end
			check("ord trigger starts", n_ord, 32'(c[0]) + 32'(c[1]));
			check("pre trigger starts", n_pre, 32'(c[0]) + 32'(c[1]));
		end
		$display("test edges done");
	endtask

	// Sequence end flag, per-channel flag, overflow and its mask
	task t_status;
		n_chan <= 4'h3;
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0);
		bus(1'b1, ACTC_MODE_OFS, 32'h1);
		bus(1'b1, ACTC_MASK_OFS, 32'h5);
		repeat (20) @(posedge clk);
		bus(1'b0, ACTC_STATUS_OFS, 32'h0);
		// Both groups run a sequence, so an early channel end on either leaves irq low
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0000_4040);
		while (ord_done !== 1'b1)
			@(posedge clk);
		repeat (2) @(posedge clk);
		check("irq mid sequence", irq, 32'h0);
		repeat (12) @(posedge clk);
		check("irq after last", irq, 32'h1);
		bus(1'b0, ACTC_STATUS_OFS, 32'h0);
		check("status no overflow", rd, 32'h7);
		check("irq after read", irq, 32'h0);
		bus(1'b1, ACTC_MASK_OFS, 32'h0);
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0003_0040);
		check("overflow detect on", ovf_en, 32'h1);
		repeat (20) @(posedge clk);
		check("irq masked", irq, 32'h0);
		bus(1'b1, ACTC_MASK_OFS, 32'h8);
		check("irq overflow", irq, 32'h1);
		bus(1'b0, ACTC_STATUS_OFS, 32'h0);
		check("status per channel", rd, 32'hb);
		check("irq cleared", irq, 32'h0);
		// A read-out between runs frees the slot, so one channel gives no overflow
		n_chan <= 4'h1;
		result_read <= 1'b1;
		@(posedge clk);
		result_read <= 1'b0;
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0003_0040);
		repeat (20) @(posedge clk);
		check("irq no overflow", irq, 32'h0);
		bus(1'b0, ACTC_STATUS_OFS, 32'h0);
		check("status after read-out", rd, 32'h3);
		$display("test status done");
	endtask

	// Reset in mid-run returns every field and pin to zero
	task t_rereset;
		bus(1'b1, ACTC_CTRL2_OFS, 32'h0003_3f3f);
		bus(1'b0, ACTC_CTRL2_OFS, 32'h0);
		check("fields before reset", rd, 32'h0003_3f3f);
		check("align pin set", left_align, 32'h1);
		reset <= 1'b1;
		repeat (2) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		check("align pin after reset", left_align, 32'h0);
		check("overflow detect after reset", ovf_en, 32'h0);
		bus(1'b0, ACTC_CTRL2_OFS, 32'h0);
		check("fields after reset", rd, 32'h0);
		$display("test mid-run reset done");
	endtask

	task report_and_stop;
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask

	initial
	begin
		repeat (16) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		t_reset;
		t_soft;
		t_edge;
		t_status;
		t_rereset;
		report_and_stop;
	end

	// Whole run needs well under a thousand cycles
	initial
	begin
		repeat (5000) @(posedge clk);
		n_fail++;
		report_and_stop;
	end
endmodule
